/* File: hdl/preset_speed_map.vh */
`ifndef PRESET_SPEED_MAP_VH
`define PRESET_SPEED_MAP_VH

// Register byte offsets.
`define REG_MODE 8'h00
`define REG_ALLOC 8'h04
`define REG_PRESET1 8'h08
`define REG_PRESET2 8'h0c
`define REG_PRESET3 8'h10
`define REG_DECEL 8'h14
`define REG_STATUS 8'h18
`define REG_SPEED 8'h1c

// Allocation register bit positions.
`define ALLOC_CHANGED_BIT 0
`define ALLOC_CSEL_BIT 1
`define ALLOC_SPD_BIT 2

// Reset values.
`define RST_MODE 4'h3
`define RST_ALLOC 3'h0
`define RST_PRESET1 14'h0064
`define RST_PRESET2 14'h00c8
`define RST_PRESET3 14'h012c
`define RST_DECEL 16'h0000

// Control mode field values.
`define MODE_PRESET 4'h3
`define MODE_PS_SPD 4'h4
`define MODE_PS_POS 4'h5
`define MODE_PS_TRQ 4'h6
`define MODE_POS_SPD 4'h7
`define MODE_POS_TRQ 4'h8
`define MODE_TRQ_SPD 4'h9
`define MODE_SPD_ZCL 4'ha
`define MODE_POS_INH 4'hb

// Active control method codes.
`define METH_PRESET 2'h0
`define METH_SPEED 2'h1
`define METH_POS 2'h2
`define METH_TORQUE 2'h3

// Speed setting range top, rpm.
`define SPEED_SETTING_MAX 14'h2710

// Timing.
`define CLK_MHZ 100
`define SEL_LATENCY_MAX_US 2000
`define SEL_LATENCY_MAX_CYC (`SEL_LATENCY_MAX_US * `CLK_MHZ)
`define DECEL_STEP_CYC (`CLK_MHZ * 1000 / `SPEED_SETTING_MAX)
`define FILTER_CYC_DEFAULT 16'h03e8

`endif

/* File: hdl/preset_speed_mode_selector.v */
// Overview of operation
// - Both speed selects off in preset operation gives zero speed, any direction.
// - Select A off, B on uses preset speed one.
// - Select A on, B on uses preset speed two.
// - Select A on, B off uses preset speed three.
// - Direction input off means forward, on means reverse.
// - Modes 4, 5, 6 pair preset speed with speed, position, torque.
// - Modes 7 to B pair pos/spd, pos/trq, trq/spd, spd/zclamp, pos/inhibit.
// - Modes 4-6 factory: both selects off runs alternate, else preset speed.
// - Switching into preset speed control is accepted at any time.
// - Shared speed select changes reach the decision within 2 ms.
// - Leaving preset for position decelerates over decel time, then waits for stop.
// - Modes 4-6 changed allocation: control select on runs alternate, off preset.
// - Changed allocation decodes speed from dedicated inputs, same table.
// - Modes 7-9 factory: shared direction on gives spd/trq/spd, off pos/pos/trq.
// - Modes 7-9 changed: control select chooses the method, same table.
// - Mode 3 selects preset speed control alone.
// - Factory allocation reuses the shared pins as direction and speed selects.
// - Preset speeds range 0 to 10000 rpm, clamped to motor maximum.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "preset_speed_map.vh"

module preset_speed_mode_selector #(
    parameter [13:0] MOTOR_MAX_SPEED = `SPEED_SETTING_MAX,
    parameter [15:0] FILTER_CYCLES   = `FILTER_CYC_DEFAULT
) (
    input  wire        i_core_clk,
    input  wire        i_rst_b,
    input  wire        i_ce,
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wr_data,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rd_data,
    input  wire        i_shared_direction_input_b,
    input  wire        i_shared_speed_select_a_b,
    input  wire        i_shared_speed_select_b_b,
    input  wire        i_dedicated_direction_input_b,
    input  wire        i_dedicated_speed_select_a_b,
    input  wire        i_dedicated_speed_select_b_b,
    input  wire        i_control_select_b,
    input  wire        i_motor_stopped,
    output reg  [1:0]  o_method,
    output reg         o_sub_mode,
    output reg  [15:0] o_speed_ref,
    output reg         o_reverse,
    output reg         o_decelerating
);

localparam [1:0] ST_PRESET = 2'h0;
localparam [1:0] ST_DECEL  = 2'h1;
localparam [1:0] ST_ALT    = 2'h2;
localparam integer STEP_CYC_I = `DECEL_STEP_CYC;
localparam [23:0]  STEP_CYC   = STEP_CYC_I[23:0];

////////////////////////////////////////////////////////////////////////
// Clamp a speed setting to the motor maximum.
function [13:0] clamp_speed;
    input [13:0] v;
    begin
        clamp_speed = (v > MOTOR_MAX_SPEED) ? MOTOR_MAX_SPEED : v;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Setup registers.
reg  [3:0]  control_mode_field;
reg  [2:0]  alloc;
reg  [13:0] preset_speed_one;
reg  [13:0] preset_speed_two;
reg  [13:0] preset_speed_three;
reg  [15:0] soft_start_decel_time;
reg  [1:0]  state;
reg  [13:0] cur_mag;

wire input_allocation_mode    = alloc[`ALLOC_CHANGED_BIT];
wire method_select_pin_assign = alloc[`ALLOC_CSEL_BIT];
wire preset_pins_assign       = alloc[`ALLOC_SPD_BIT];

always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        control_mode_field    <= `RST_MODE;
        alloc                 <= `RST_ALLOC;
        preset_speed_one      <= `RST_PRESET1;
        preset_speed_two      <= `RST_PRESET2;
        preset_speed_three    <= `RST_PRESET3;
        soft_start_decel_time <= `RST_DECEL;
    end else if (i_ce && i_wr) begin
        case (i_addr)
            `REG_MODE: begin
                control_mode_field <= i_wr_data[3:0];
            end
            `REG_ALLOC: begin
                alloc <= i_wr_data[2:0];
            end
            `REG_PRESET1: begin
                preset_speed_one <= clamp_speed(i_wr_data[13:0]);
            end
            `REG_PRESET2: begin
                preset_speed_two <= clamp_speed(i_wr_data[13:0]);
            end
            `REG_PRESET3: begin
                preset_speed_three <= clamp_speed(i_wr_data[13:0]);
            end
            `REG_DECEL: begin
                soft_start_decel_time <= i_wr_data[15:0];
            end
            default: begin
            end
        endcase
    end
end

// Read data stand only in the cycle after the strobe.
always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_rd_data <= 32'h00000000;
    end else if (i_ce) begin
        o_rd_data <= 32'h00000000;
        if (i_rd) begin
            case (i_addr)
                `REG_MODE:    o_rd_data <= {28'h0000000, control_mode_field};
                `REG_ALLOC:   o_rd_data <= {29'h00000000, alloc};
                `REG_PRESET1: o_rd_data <= {18'h00000, preset_speed_one};
                `REG_PRESET2: o_rd_data <= {18'h00000, preset_speed_two};
                `REG_PRESET3: o_rd_data <= {18'h00000, preset_speed_three};
                `REG_DECEL:   o_rd_data <= {16'h0000, soft_start_decel_time};
                `REG_STATUS:  o_rd_data <= {26'h0000000, o_sub_mode, o_reverse,
                                            state, o_method};
                `REG_SPEED:   o_rd_data <= {16'h0000, o_speed_ref};
                default:      o_rd_data <= 32'h00000000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Pin synchronisers and a stability filter.
reg  [6:0]  pin_meta;
reg  [6:0]  pin_sync;
reg  [6:0]  pin_on;
reg  [15:0] filt_cnt;
wire [6:0]  pin_raw = {i_control_select_b,
                       i_dedicated_direction_input_b,
                       i_dedicated_speed_select_a_b,
                       i_dedicated_speed_select_b_b,
                       i_shared_direction_input_b,
                       i_shared_speed_select_a_b,
                       i_shared_speed_select_b_b};

always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        pin_meta <= 7'h7f;
        pin_sync <= 7'h7f;
    end else if (i_ce) begin
        pin_meta <= pin_raw;
        pin_sync <= pin_meta;
    end
end

always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        pin_on   <= 7'h00;
        filt_cnt <= 16'h0000;
    end else if (i_ce) begin
        if (~pin_sync == pin_on) begin
            filt_cnt <= 16'h0000;
        end else if (filt_cnt >= FILTER_CYCLES) begin
            pin_on   <= ~pin_sync;
            filt_cnt <= 16'h0000;
        end else begin
            filt_cnt <= filt_cnt + 16'h0001;
        end
    end
end

wire csel_pin = pin_on[6];
wire ded_dir  = pin_on[5];
wire ded_a    = pin_on[4];
wire ded_b    = pin_on[3];
wire sh_dir   = pin_on[2];
wire sh_a     = pin_on[1];
wire sh_b     = pin_on[0];

////////////////////////////////////////////////////////////////////////
// Method and speed decode.
reg        eff_dir;
reg        eff_a;
reg        eff_b;
reg        csel;
reg        sel;
reg        want_preset;
reg [1:0]  alt_meth;
reg        next_sub;
reg [13:0] target_mag;

always @* begin
    if (input_allocation_mode) begin
        eff_dir = preset_pins_assign & ded_dir;
        eff_a   = preset_pins_assign & ded_a;
        eff_b   = preset_pins_assign & ded_b;
    end else begin
        eff_dir = sh_dir;
        eff_a   = sh_a;
        eff_b   = sh_b;
    end
    csel = input_allocation_mode & method_select_pin_assign & csel_pin;
    sel = input_allocation_mode ? csel : sh_dir;
    want_preset = 1'b0;
    alt_meth    = `METH_SPEED;
    next_sub    = 1'b0;
    case (control_mode_field)
        `MODE_PRESET: begin
            want_preset = 1'b1;
        end
        `MODE_PS_SPD, `MODE_PS_POS, `MODE_PS_TRQ: begin
            want_preset = input_allocation_mode ? ~csel : (eff_a | eff_b);
            if (control_mode_field == `MODE_PS_POS)
                alt_meth = `METH_POS;
            else if (control_mode_field == `MODE_PS_TRQ)
                alt_meth = `METH_TORQUE;
            else
                alt_meth = `METH_SPEED;
        end
        `MODE_POS_SPD: begin
            alt_meth = sel ? `METH_SPEED : `METH_POS;
        end
        `MODE_POS_TRQ: begin
            alt_meth = sel ? `METH_TORQUE : `METH_POS;
        end
        `MODE_TRQ_SPD: begin
            alt_meth = sel ? `METH_SPEED : `METH_TORQUE;
        end
        `MODE_SPD_ZCL: begin
            alt_meth = `METH_SPEED;
            next_sub = sel;
        end
        `MODE_POS_INH: begin
            alt_meth = `METH_POS;
            next_sub = sel;
        end
        default: begin
            alt_meth = `METH_SPEED;
        end
    endcase
    case ({eff_a, eff_b})
        2'b00: target_mag = 14'h0000;
        2'b01: target_mag = clamp_speed(preset_speed_one);
        2'b11: target_mag = clamp_speed(preset_speed_two);
        default: target_mag = clamp_speed(preset_speed_three);
    endcase
end

////////////////////////////////////////////////////////////////////////
// Control state machine with the stop ramp.
reg  [1:0]  next_state;
reg  [23:0] step_cnt;
reg         rev;
wire [23:0] step_len = {8'h00, soft_start_decel_time} * STEP_CYC;

always @* begin
    next_state = state;
    case (state)
        ST_PRESET: begin
            if (!want_preset)
                next_state = (alt_meth == `METH_POS) ? ST_DECEL : ST_ALT;
        end
        ST_DECEL: begin
            if (want_preset)
                next_state = ST_PRESET;
            else if (cur_mag == 14'h0000 && i_motor_stopped)
                next_state = ST_ALT;
        end
        ST_ALT: begin
            if (want_preset)
                next_state = ST_PRESET;
        end
        default: begin
            next_state = ST_PRESET;
        end
    endcase
end

always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        state    <= ST_PRESET;
        cur_mag  <= 14'h0000;
        rev      <= 1'b0;
        step_cnt <= 24'h000000;
    end else if (i_ce) begin
        state <= next_state;
        if (next_state == ST_PRESET) begin
            cur_mag  <= target_mag;
            rev      <= eff_dir;
            step_cnt <= 24'h000000;
        end else if (state == ST_DECEL) begin
            if (soft_start_decel_time == 16'h0000) begin
                cur_mag <= 14'h0000;
            end else if (step_cnt + 24'h000001 >= step_len) begin
                step_cnt <= 24'h000000;
                if (cur_mag != 14'h0000)
                    cur_mag <= cur_mag - 14'h0001;
            end else begin
                step_cnt <= step_cnt + 24'h000001;
            end
        end else if (next_state == ST_ALT) begin
            cur_mag <= 14'h0000;
        end
    end
end

always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_method       <= `METH_PRESET;
        o_sub_mode     <= 1'b0;
        o_speed_ref    <= 16'h0000;
        o_reverse      <= 1'b0;
        o_decelerating <= 1'b0;
    end else if (i_ce) begin
        o_method       <= (state == ST_ALT) ? alt_meth : `METH_PRESET;
        o_sub_mode     <= (state == ST_ALT) ? next_sub : 1'b0;
        o_reverse      <= rev & (cur_mag != 14'h0000);
        o_decelerating <= (state == ST_DECEL);
        o_speed_ref    <= rev ? (16'h0000 - {2'b00, cur_mag}) : {2'b00, cur_mag};
    end
end

endmodule // preset_speed_mode_selector

`default_nettype wire

/* File: testbench/preset_speed_mode_selector_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "preset_speed_map.vh"

module preset_speed_mode_selector_checker #(
    parameter [13:0] MOTOR_MAX_SPEED = `SPEED_SETTING_MAX
) (
    input wire logic        i_core_clk,
    input wire logic        i_rst_b,
    input wire logic        i_ce,
    input wire logic        i_rd,
    input wire logic [31:0] o_rd_data,
    input wire logic [1:0]  o_method,
    input wire logic        o_sub_mode,
    input wire logic [15:0] o_speed_ref,
    input wire logic        o_reverse,
    input wire logic        o_decelerating
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    a_zero_fwd: assert property (o_speed_ref == 16'h0000 |-> !o_reverse)
        else $error("reverse flagged on zero reference");
    a_ref_sign: assert property (o_speed_ref != 16'h0000 |-> o_reverse == o_speed_ref[15])
        else $error("reverse flag disagrees with reference sign");
    a_alt_noref: assert property (o_method != `METH_PRESET |-> o_speed_ref == 16'h0000)
        else $error("alternate method with nonzero reference");
    a_decel_preset: assert property (o_decelerating |-> o_method == `METH_PRESET)
        else $error("ramp outside preset method");
    a_pos_stopped: assert property ((o_decelerating && o_speed_ref != 16'h0000) |=> o_method != `METH_POS)
        else $error("position entered before standstill");
    a_sub_alt: assert property (o_sub_mode |-> o_method != `METH_PRESET)
        else $error("sub mode flagged in preset method");
    a_ref_clamp: assert property ($signed(o_speed_ref) <= $signed({2'b00, MOTOR_MAX_SPEED})
        && $signed(o_speed_ref) >= -$signed({2'b00, MOTOR_MAX_SPEED}))
        else $error("reference beyond motor maximum");
    a_rd_idle: assert property ((i_ce && !i_rd) |=> o_rd_data == 32'h0)
        else $error("read data outside read answer cycle");

    cover property (o_decelerating);
    cover property (o_method == `METH_POS);
    cover property (o_reverse);
endmodule // preset_speed_mode_selector_checker

bind preset_speed_mode_selector preset_speed_mode_selector_checker #(.MOTOR_MAX_SPEED(MOTOR_MAX_SPEED)) chk_u (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .o_method(o_method), .o_sub_mode(o_sub_mode), .o_speed_ref(o_speed_ref), .o_reverse(o_reverse),
    .o_decelerating(o_decelerating));
`default_nettype wire

/* File: testbench/contact_model.sv */
`timescale 1ns/10ps
`default_nettype none

module contact_model (
    input  wire logic       i_core_clk,
    input  wire logic [6:0] i_on,
    output var  logic [6:0] o_pin_b
);
    initial o_pin_b = 7'h7f;
    always @(posedge i_core_clk) begin
        o_pin_b <= ~i_on;
    end
endmodule // contact_model
`default_nettype wire

/* File: testbench/preset_speed_mode_selector_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "preset_speed_map.vh"

module preset_speed_mode_selector_test;
    logic        core_clk, rst_b, wr_s, rd_s, stopped, ce;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] o_rd_data;
    logic [6:0]  on_v, pin_b;
    logic [1:0]  o_method;
    logic        o_sub_mode, o_reverse, o_decel;
    logic [15:0] o_speed_ref, p1, p2, p3;
    logic [3:0]  mode;
    logic [2:0]  alloc;
    int          n_mismatch, samples_checked, cyc, i;

    preset_speed_mode_selector #(.MOTOR_MAX_SPEED(14'h1388), .FILTER_CYCLES(16'h0002)) dut_u (
        .i_core_clk(core_clk), .i_rst_b(rst_b), .i_ce(ce), .i_addr(addr), .i_wr_data(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .o_rd_data(o_rd_data), .i_shared_direction_input_b(pin_b[2]),
        .i_shared_speed_select_a_b(pin_b[1]), .i_shared_speed_select_b_b(pin_b[0]),
        .i_dedicated_direction_input_b(pin_b[5]), .i_dedicated_speed_select_a_b(pin_b[4]),
        .i_dedicated_speed_select_b_b(pin_b[3]), .i_control_select_b(pin_b[6]), .i_motor_stopped(stopped),
        .o_method(o_method), .o_sub_mode(o_sub_mode), .o_speed_ref(o_speed_ref), .o_reverse(o_reverse),
        .o_decelerating(o_decel));
    contact_model sw_u (.i_core_clk(core_clk), .i_on(on_v), .o_pin_b(pin_b));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [18:0] expect_out(input logic [3:0] m, input logic [2:0] al, input logic [6:0] on);
        logic cs, dir, a, b, sel, sub;
        logic [1:0] meth;
        logic [15:0] mag;
        cs = al[0] & al[1] & on[6];
        {dir, a, b} = al[0] ? (al[2] ? on[5:3] : 3'h0) : on[2:0];
        sel = al[0] ? cs : on[2];
        mag = ({a, b} == 2'b01) ? p1 : ({a, b} == 2'b11) ? p2 : ({a, b} == 2'b10) ? p3 : 16'h0000;
        sub = 1'b0;
        case (m)
            4'h3: meth = `METH_PRESET;
            4'h4, 4'h5, 4'h6: begin
                meth = `METH_PRESET;
                if (al[0] ? cs : ({on[1], on[0]} == 2'b00))
                    meth = (m == 4'h4) ? `METH_SPEED : (m == 4'h5) ? `METH_POS : `METH_TORQUE;
            end
            4'h7: meth = sel ? `METH_SPEED : `METH_POS;
            4'h8: meth = sel ? `METH_TORQUE : `METH_POS;
            4'h9: meth = sel ? `METH_SPEED : `METH_TORQUE;
            4'ha: begin meth = `METH_SPEED; sub = sel; end
            4'hb: begin meth = `METH_POS; sub = sel; end
            default: meth = `METH_SPEED;
        endcase
        if (meth != `METH_PRESET) mag = 16'h0000;
        return {sub, meth, dir ? -mag : mag};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a; wdata <= d; wr_s <= 1'b1;
        @(posedge core_clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        addr <= a; rd_s <= 1'b1;
        @(posedge core_clk);
        rd_s <= 1'b0;
        #1 chk(o_rd_data, e);
    endtask

    task automatic setup(input logic [3:0] m, input logic [2:0] al);
        mode = m; alloc = al;
        wr(`REG_MODE, {28'h0, m});
        wr(`REG_ALLOC, {29'h0, al});
    endtask

    task automatic settle(input logic [6:0] on);
        logic [18:0] e;
        e = expect_out(mode, alloc, on);
        @(posedge core_clk);
        on_v <= on;
        repeat (14) @(posedge core_clk);
        #1 chk({13'h0, o_sub_mode, o_method, o_speed_ref}, {13'h0, e});
        chk({31'h0, o_reverse}, {31'h0, (e[15:0] != 16'h0000) & e[15]});
    endtask

    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0; wr_s = 1'b0; rd_s = 1'b0; addr = 8'h00; wdata = 32'h0; stopped = 1'b1; on_v = 7'h00;
        n_mismatch = 0; samples_checked = 0; cyc = 0; mode = 4'h3; alloc = 3'h0; ce = 1'b1;
        p1 = 16'h0064; p2 = 16'h00c8; p3 = 16'h012c;
        void'($urandom(92205));
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(`REG_MODE, 32'h3); rd(`REG_ALLOC, 32'h0); rd(`REG_PRESET1, 32'h64);
        rd(`REG_PRESET2, 32'hc8); rd(`REG_PRESET3, 32'h12c); rd(`REG_DECEL, 32'h0);
        wr(8'h20, 32'h1234); rd(8'h20, 32'h0);
        wr(`REG_PRESET1, 32'h2710); p1 = 16'h1388; rd(`REG_PRESET1, 32'h1388);
        p3 = 16'($urandom_range(5000, 0)); wr(`REG_PRESET3, {16'h0, p3});
        $display("registers done");
        for (i = 0; i < 72; i++) begin
            if (i % 8 == 0) setup(4'(3 + i / 8), 3'h0);
            settle(7'(i % 8));
        end
        $display("mode table done");
        for (i = 0; i < 60; i++) begin
            setup(4'($urandom_range(15, 0)), 3'($urandom_range(7, 0)));
            settle(7'($urandom_range(127, 0)));
        end
        $display("random done");
        @(posedge core_clk) rst_b <= 1'b0;
        #1 chk({13'h0, o_sub_mode, o_method, o_speed_ref}, 32'h0);
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        p1 = 16'h0064; p2 = 16'h00c8; p3 = 16'h012c; mode = 4'h3; alloc = 3'h0;
        rd(`REG_MODE, 32'h3); rd(`REG_PRESET3, 32'h12c);
        settle(7'h07);
        $display("second reset done");
        setup(4'h3, 3'h0);
        settle(7'h00);
        @(posedge core_clk) on_v <= 7'h01;
        repeat (2) @(posedge core_clk);
        on_v <= 7'h00;
        for (i = 0; i < 12; i++) begin
            @(posedge core_clk) #1 chk({16'h0, o_speed_ref}, 32'h0);
        end
        $display("glitch done");
        settle(7'h01);
        @(posedge core_clk) ce <= 1'b0;
        wr(`REG_PRESET1, 32'h5);
        @(posedge core_clk) on_v <= 7'h00;
        repeat (14) @(posedge core_clk);
        #1 chk({16'h0, o_speed_ref}, {16'h0, p1});
        @(posedge core_clk) ce <= 1'b1;
        rd(`REG_PRESET1, {16'h0, p1});
        settle(7'h00);
        $display("enable done");
        setup(4'h5, 3'h0);
        p1 = 16'h0014; wr(`REG_PRESET1, 32'h14); wr(`REG_DECEL, 32'h1);
        stopped <= 1'b0;
        settle(7'h05);
        @(posedge core_clk) on_v <= 7'h00;
        repeat (60) @(posedge core_clk);
        #1 chk({30'h0, o_decel, o_speed_ref != 16'h0000}, 32'h3);
        repeat (300) @(posedge core_clk);
        #1 chk({13'h0, o_decel, o_method, o_speed_ref}, {13'h0, 1'b1, `METH_PRESET, 16'h0000});
        @(posedge core_clk) stopped <= 1'b1;
        settle(7'h00);
        settle(7'h01);
        $display("decel done");
        results();
    end
endmodule // preset_speed_mode_selector_test
`default_nettype wire
